//--- include/fcrcd_pkg.sv
// shared constants and types of the frame command decoder
package fcrcd_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int FRAME_W = 48;
  localparam int DATA_HI = 47;
  localparam int DATA_LO = 32;
  localparam int CNT_HI = 39;
  localparam int DIR_BIT = 31;
  localparam int ADDR_HI = 30;
  localparam int ADDR_LO = 24;
  localparam int NODE_HI = 21;
  localparam int NODE_LO = 16;
  localparam int CMD_HI = 9;
  localparam int CMD_LO = 8;
  // ----------------------------------------
  // crc engine
  // ----------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_SEED = 8'h42;
  localparam logic [7:0] CRC_GOOD = 8'h00;
  localparam logic [5:0] CHECK_LAST = 6'h2f;
  // direct form: only the 40 body bits are shifted, never the zero crc byte
  localparam logic [5:0] GEN_LAST = 6'h28;
  // ----------------------------------------
  // register space and reset values
  // ----------------------------------------
  localparam logic [6:0] NODE_SETUP_ADDR = 7'h01;
  localparam logic [6:0] MAX_COUNT = 7'h7f;
  localparam logic [5:0] RST_NODE = 6'h00;
  localparam logic [3:0] RST_SEQ = 4'h0;
  // ----------------------------------------
  // command codes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_NOP = 2'h0,
    CMD_READ = 2'h1,
    CMD_LWR = 2'h2,
    CMD_GWR = 2'h3
  } fcrcd_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_DECODE = 3'h3,
    ST_FETCH = 3'h2,
    ST_GEN = 3'h6,
    ST_SEND = 3'h7
  } fcrcd_state_t;
endpackage

//--- rtl/fcrcd_crc8.sv
// serial msb-first crc-8 shift register
`timescale 1ns/100ps
module fcrcd_crc8
  import fcrcd_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // control
  input wire logic load_i,
  input wire logic shift_i,
  input wire logic bit_i,
  // remainder
  output logic [7:0] crc_o
);
  // ----------------------------------------
  // shift register
  // ----------------------------------------
  logic [7:0] crc_ff; // running remainder
  logic fb; // feedback bit
  logic [7:0] nxt_crc; // shifted remainder

  assign fb = crc_ff[7] ^ bit_i;
  assign nxt_crc = {crc_ff[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);

  // load wins over shift
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      crc_ff <= CRC_SEED;
    else if (load_i)
      crc_ff <= CRC_SEED;
    else if (shift_i)
      crc_ff <= nxt_crc;
  end

  assign crc_o = crc_ff;
endmodule // fcrcd_crc8

//--- rtl/fcrcd_decoder.sv
// frame check, command decode and read response builder
// What this block does
// - crc-8 polynomial 0x2f on every frame
// - crc register starts at seed 0x42
// - response crc over frame, zero crc byte
// - check all 48 bits, zero means good
// - fixed field positions inside the frame
// - command codes nop, read, local, global
// - read count from bits 39:32, zero=1
// - address advances per word, wraps at 0x7f
// - response flag 1, reserved 0, cmd 01
// - reserved register reads return zero data
// - 4-bit response counter, wraps, starts zero
// - uninitialised node is read-only except setup
// - node address zero: only setup writable
// - local write updates, sends no response
// - read-only and reserved writes store nothing
// - global write executes at every initialised node, no answer
// - nop restarts timeout, nothing else
// - initialised node ignores response frames
// - bad crc: silent, fault flag, count up
`timescale 1ns/100ps
module fcrcd_decoder
  import fcrcd_pkg::*;
#(
  parameter int ERR_W = 8 // error counter width
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // received frame
  input wire logic [47:0] rx_frame_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  // response frame
  output logic [47:0] tx_frame_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // register space
  output logic [6:0] reg_addr_o,
  input wire logic [15:0] reg_rd_data_i,
  input wire logic reg_reserved_i,
  input wire logic reg_writable_i,
  output logic reg_wr_en_o,
  output logic [15:0] reg_wr_data_o,
  // status
  output logic [5:0] node_address_o,
  output logic [3:0] response_sequence_count_o,
  output logic link_fault_flag_o,
  input wire logic link_fault_clear_i,
  output logic [ERR_W-1:0] link_error_count_o,
  output logic timeout_restart_o
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (ERR_W < 1 || ERR_W > 16)
  begin : g_bad_err_w
    $error("ERR_W must lie in 1..16");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  fcrcd_state_t state_ff; // sequencer state
  fcrcd_state_t nxt_state; // next state
  logic [47:0] frame_ff; // received frame
  logic [47:0] sh_ff; // bit shifter into crc
  logic [5:0] cnt_ff; // bit counter
  logic [6:0] rem_ff; // words still to send
  logic is_read_ff; // current job is a read
  logic is_global_ff; // current write is global
  logic [6:0] addr_ff; // register address
  logic [15:0] wdata_ff; // write data
  logic wr_en_ff; // write strobe
  logic [47:0] tx_frame_ff; // response frame
  logic tx_valid_ff; // response offered
  logic rx_ready_ff; // ready for a frame
  logic [5:0] node_ff; // own node address
  logic [3:0] seq_ff; // response counter
  logic fault_ff; // sticky link fault
  logic [ERR_W-1:0] err_ff; // bad frame count
  logic tmo_ff; // timeout restart pulse
  logic [7:0] crc_q; // crc remainder

  // ----------------------------------------
  // frame fields
  // ----------------------------------------
  wire [1:0] f_cmd = frame_ff[CMD_HI:CMD_LO];
  wire [5:0] f_node = frame_ff[NODE_HI:NODE_LO];
  wire [6:0] f_addr = frame_ff[ADDR_HI:ADDR_LO];
  wire f_dir = frame_ff[DIR_BIT];
  wire [15:0] f_data = frame_ff[DATA_HI:DATA_LO];
  wire [7:0] f_cnt = frame_ff[CNT_HI:DATA_LO];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire in_decode = state_ff == ST_DECODE;
  wire in_fetch = state_ff == ST_FETCH;
  wire crc_ok = crc_q == CRC_GOOD;
  wire initialised = node_ff != RST_NODE;
  wire node_hit = f_node == node_ff;
  wire ignore_resp = f_dir & initialised;
  wire accept = in_decode & crc_ok & ~ignore_resp;
  wire bad_frame = in_decode & ~crc_ok;
  wire do_nop = accept & node_hit & (f_cmd == CMD_NOP);
  wire do_read = accept & node_hit & (f_cmd == CMD_READ);
  wire do_lwr = accept & node_hit & (f_cmd == CMD_LWR);
  wire do_gwr = accept & (f_cmd == CMD_GWR);
  // zero counts as one, larger than max clamps
  wire [6:0] count_sel = (f_cnt == 8'h00) ? 7'h01 :
    (f_cnt[7] ? MAX_COUNT : f_cnt[6:0]);

  // ----------------------------------------
  // write gating
  // ----------------------------------------
  wire at_setup = addr_ff == NODE_SETUP_ADDR;
  // setup is not reachable by a global write
  wire wr_permit = initialised ? ~(is_global_ff & at_setup) :
    (at_setup & ~is_global_ff);
  wire wr_job = in_fetch & ~is_read_ff;
  wire setup_wr = wr_job & wr_permit & at_setup;
  wire ext_wr = wr_job & wr_permit & ~at_setup &
    reg_writable_i & ~reg_reserved_i;

  // ----------------------------------------
  // response build
  // ----------------------------------------
  wire [15:0] rd_word = at_setup ? {10'h000, node_ff} :
    (reg_reserved_i ? 16'h0000 : reg_rd_data_i);
  wire [47:0] resp_base = {rd_word, 1'b1, addr_ff, 2'h0, node_ff,
    seq_ff, 2'h0, CMD_READ, 8'h00};
  wire gen_done = (state_ff == ST_GEN) & (cnt_ff == GEN_LAST);
  wire tx_take = tx_valid_ff & tx_ready_i;
  wire rx_take = rx_ready_ff & rx_valid_i;
  wire last_word = rem_ff == 7'h01;

  // ----------------------------------------
  // crc engine
  // ----------------------------------------
  wire crc_load = rx_take | (in_fetch & is_read_ff);
  wire crc_shift = (state_ff == ST_CHECK) |
    ((state_ff == ST_GEN) & (cnt_ff != GEN_LAST));

  fcrcd_crc8 u_crc
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .load_i(crc_load),
    .shift_i(crc_shift),
    .bit_i(sh_ff[47]),
    .crc_o(crc_q)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // next state selection
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (rx_take)
          nxt_state = ST_CHECK;
      ST_CHECK:
        if (cnt_ff == CHECK_LAST)
          nxt_state = ST_DECODE;
      ST_DECODE:
        if (do_read | do_lwr | do_gwr)
          nxt_state = ST_FETCH;
        else
          nxt_state = ST_IDLE;
      ST_FETCH:
        nxt_state = is_read_ff ? ST_GEN : ST_IDLE;
      ST_GEN:
        if (gen_done)
          nxt_state = ST_SEND;
      ST_SEND:
        if (tx_take)
          nxt_state = last_word ? ST_IDLE : ST_FETCH;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // bit counter restarts on every state change
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_ff <= 6'h00;
    else if (nxt_state != state_ff)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= cnt_ff + 6'h01;
  end

  // frame capture and bit shifter
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      frame_ff <= 48'h000000000000;
      sh_ff <= 48'h000000000000;
    end
    else if (rx_take)
    begin
      frame_ff <= rx_frame_i;
      sh_ff <= rx_frame_i;
    end
    else if (in_fetch & is_read_ff)
      sh_ff <= resp_base;
    else if (crc_shift)
      sh_ff <= {sh_ff[46:0], 1'b0};
  end

  // job parameters: address, count, kind
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      addr_ff <= 7'h00;
      rem_ff <= 7'h00;
      is_read_ff <= 1'b0;
      is_global_ff <= 1'b0;
      wdata_ff <= 16'h0000;
    end
    else if (in_decode)
    begin
      addr_ff <= f_addr;
      rem_ff <= count_sel;
      is_read_ff <= do_read;
      is_global_ff <= do_gwr;
      wdata_ff <= f_data;
    end
    else if (tx_take & ~last_word)
    begin
      addr_ff <= addr_ff + 7'h01;
      rem_ff <= rem_ff - 7'h01;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // strobe to the register space
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wr_en_ff <= 1'b0;
    else
      wr_en_ff <= ext_wr;
  end

  // own node address in the setup register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      node_ff <= RST_NODE;
    else if (setup_wr)
      node_ff <= wdata_ff[5:0];
  end

  // ----------------------------------------
  // response output
  // ----------------------------------------
  // frame body first, crc byte at the end
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tx_frame_ff <= 48'h000000000000;
    else if (in_fetch & is_read_ff)
      tx_frame_ff <= resp_base;
    else if (gen_done)
      tx_frame_ff <= {tx_frame_ff[47:8], crc_q};
  end

  // offer holds until taken
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tx_valid_ff <= 1'b0;
    else if (gen_done)
      tx_valid_ff <= 1'b1;
    else if (tx_take)
      tx_valid_ff <= 1'b0;
  end

  // counter moves after each sent response
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      seq_ff <= RST_SEQ;
    else if (tx_take)
      seq_ff <= seq_ff + 4'h1;
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  // sticky fault: a new error beats the clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      fault_ff <= 1'b0;
    else
      fault_ff <= bad_frame | (fault_ff & ~link_fault_clear_i);
  end

  // saturating error counter
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      err_ff <= '0;
    else if (bad_frame & ~(&err_ff))
      err_ff <= err_ff + 1'b1;
  end

  // timeout restart and frame ready
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tmo_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
    end
    else
    begin
      tmo_ff <= do_nop;
      rx_ready_ff <= nxt_state == ST_IDLE;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rx_ready_o = rx_ready_ff;
  assign tx_frame_o = tx_frame_ff;
  assign tx_valid_o = tx_valid_ff;
  assign reg_addr_o = addr_ff;
  assign reg_wr_en_o = wr_en_ff;
  assign reg_wr_data_o = wdata_ff;
  assign node_address_o = node_ff;
  assign response_sequence_count_o = seq_ff;
  assign link_fault_flag_o = fault_ff;
  assign link_error_count_o = err_ff;
  assign timeout_restart_o = tmo_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_bad_frame;
    in_decode && !crc_ok;
  endsequence

  sequence s_write_job;
    in_decode && (do_lwr || do_gwr);
  endsequence

  seed_load_a: assert property (crc_load |=> crc_q == CRC_SEED)
    else $error("crc not seeded");

  fault_set_a: assert property (s_bad_frame |=> link_fault_flag_o)
    else $error("fault flag not set on bad crc");

  err_count_a: assert property (s_bad_frame |=>
    (link_error_count_o == $past(link_error_count_o) + 1'b1) ||
    (&link_error_count_o))
    else $error("error count not advanced");

  write_silent_a: assert property (s_write_job |=> !tx_valid_o [*8])
    else $error("write produced a response");

  resp_fields_a: assert property (tx_valid_o |-> tx_frame_o[31] &&
    tx_frame_o[23:22] == 2'h0 && tx_frame_o[11:10] == 2'h0 &&
    tx_frame_o[9:8] == CMD_READ && tx_frame_o[21:16] == node_address_o)
    else $error("bad response fields");

  seq_step_a: assert property (tx_valid_o && tx_ready_i |=>
    response_sequence_count_o == $past(response_sequence_count_o) + 4'h1)
    else $error("response counter not stepped");

  addr_step_a: assert property (tx_take && !last_word |=>
    reg_addr_o == $past(reg_addr_o) + 7'h01)
    else $error("burst address not advanced");

  read_answer_a: assert property (do_read |-> ##[1:60] tx_valid_o)
    else $error("read not answered");

  zero_node_wr_a: assert property (reg_wr_en_o |-> node_address_o != 6'h00)
    else $error("write while uninitialised");

  wr_target_a: assert property (reg_wr_en_o |->
    $past(reg_writable_i) && !$past(reg_reserved_i))
    else $error("write to protected register");

  reserved_zero_a: assert property (in_fetch && is_read_ff &&
    reg_reserved_i && !at_setup |=> tx_frame_o[47:32] == 16'h0000)
    else $error("reserved read not zero");

  nop_restart_a: assert property (timeout_restart_o |->
    $past(in_decode && crc_ok && f_cmd == CMD_NOP))
    else $error("stray timeout restart");

  resp_ignore_a: assert property (in_decode && crc_ok && ignore_resp |=>
    state_ff == ST_IDLE && !timeout_restart_o)
    else $error("response frame acted upon");
endmodule // fcrcd_decoder

//--- dv/fcrcd_host_model.sv
// link host model that takes response frames with random stalls
`timescale 1ns/100ps
module fcrcd_host_model
  import fcrcd_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // response link
  input wire logic [47:0] tx_frame_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [47:0] rsp_q[$]; // responses taken, oldest first
  // ----------------------------------------
  // stall and capture
  // ----------------------------------------
  // idle until the first falling edge
  initial tx_ready_o = 1'b0;
  // ready changes off the sampling edge, stalls about a third of cycles
  always @(negedge clock_i)
    tx_ready_o <= nrst_i && ($urandom % 3 != 0);
  // a response counts as taken on the edge where both are high
  always @(posedge clock_i)
    if (nrst_i && tx_valid_i && tx_ready_o)
      rsp_q.push_back(tx_frame_i);
endmodule // fcrcd_host_model

//--- dv/fcrcd_decoder_tb.sv
// self-checking testbench of the frame command decoder
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module fcrcd_decoder_tb
  import fcrcd_pkg::*;
;
  localparam int EW = 3; // narrow so saturation is reached
  logic clock_i, nrst_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic [47:0] rx_frame_i, tx_frame_o, f;
  logic [6:0] reg_addr_o, wr_addr;
  logic [15:0] reg_rd_data_i, reg_wr_data_o, wr_data;
  logic reg_reserved_i, reg_writable_i, reg_wr_en_o, link_fault_flag_o;
  logic link_fault_clear_i, timeout_restart_o, exp_fault;
  logic [5:0] node_address_o, exp_node;
  logic [3:0] response_sequence_count_o, exp_seq;
  logic [EW-1:0] link_error_count_o, exp_err;
  int err_count, checked, wr_cnt, nop_cnt;
  // ----------------------------------------
  // register space model
  // ----------------------------------------
  function automatic bit rsvd(input logic [6:0] a);
    return a == 7'h00 || (a >= 7'h12 && a <= 7'h19) || (a >= 7'h4c && a <= 7'h53);
  endfunction
  function automatic logic [15:0] rd_val(input logic [6:0] a);
    if (rsvd(a))
      return 16'h0000;
    if (a == NODE_SETUP_ADDR)
      return {10'h000, exp_node};
    return {1'b0, a, ~a, 1'b1};
  endfunction
  assign reg_rd_data_i = {1'b0, reg_addr_o, ~reg_addr_o, 1'b1};
  assign reg_reserved_i = rsvd(reg_addr_o);
  assign reg_writable_i = reg_addr_o >= 7'h02 && reg_addr_o < 7'h30;
  // ----------------------------------------
  // frame helpers
  // ----------------------------------------
  function automatic logic [47:0] seal(input logic [47:0] x);
    logic [7:0] c;
    c = CRC_SEED;
    // each body bit enters at the top, which stands for the zero byte flush
    for (int i = 47; i >= 8; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? CRC_POLY : 8'h00);
    return {x[47:8], c};
  endfunction
  // don't-care fields set to ones, bits 15:12 to 5, so they are seen to be ignored
  function automatic logic [47:0] mk(input logic [1:0] c, input logic [6:0] a,
                                     input logic [5:0] nd, input logic [15:0] d);
    return seal({d, 1'b0, a, 2'b11, nd, 4'h5, 2'b11, c, 8'h00});
  endfunction
  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  fcrcd_decoder #(.ERR_W(EW)) i_fcrcd_decoder (.clock_i(clock_i), .nrst_i(nrst_i),
    .rx_frame_i(rx_frame_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
    .tx_frame_o(tx_frame_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .reg_addr_o(reg_addr_o), .reg_rd_data_i(reg_rd_data_i),
    .reg_reserved_i(reg_reserved_i), .reg_writable_i(reg_writable_i),
    .reg_wr_en_o(reg_wr_en_o), .reg_wr_data_o(reg_wr_data_o),
    .node_address_o(node_address_o), .response_sequence_count_o(response_sequence_count_o),
    .link_fault_flag_o(link_fault_flag_o), .link_fault_clear_i(link_fault_clear_i),
    .link_error_count_o(link_error_count_o), .timeout_restart_o(timeout_restart_o));
  fcrcd_host_model i_fcrcd_host_model (.clock_i(clock_i), .nrst_i(nrst_i),
    .tx_frame_i(tx_frame_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
  // clock of 4 ns
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // count write strobes and timer restarts
  always @(posedge clock_i)
  begin
    if (reg_wr_en_o === 1'b1)
    begin
      wr_cnt++;
      wr_addr = reg_addr_o;
      wr_data = reg_wr_data_o;
    end
    if (timeout_restart_o === 1'b1)
      nop_cnt++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // offer one frame, then wait until the decoder is idle again
  task automatic send(input logic [47:0] x);
    int k;
    k = 0;
    @(negedge clock_i);
    while (rx_ready_o !== 1'b1 && k < 20000)
    begin
      @(negedge clock_i);
      k++;
    end
    rx_frame_i = x;
    rx_valid_i = 1'b1;
    @(negedge clock_i);
    rx_valid_i = 1'b0;
    rx_frame_i = ~x;
    while (rx_ready_o !== 1'b1 && k < 20000)
    begin
      @(negedge clock_i);
      k++;
    end
    if (k >= 20000)
      err_count++;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic do_frame(input logic [47:0] x, input bit bad);
    int n;
    int w0;
    int t0;
    bit own;
    bit live;
    bit wr;
    logic [6:0] a;
    logic [47:0] got;
    n = 0;
    wr = 0;
    w0 = wr_cnt;
    t0 = nop_cnt;
    a = x[30:24];
    own = (x[21:16] == exp_node);
    live = !bad && !(x[31] && exp_node != 6'h00);
    if (live && own && x[9:8] == 2'h1)
      n = (x[39:32] == 8'h00) ? 1 : ((x[39:32] > 8'h7f) ? 127 : int'(x[39:32]));
    if (live && ((x[9:8] == 2'h2 && own) || (x[9:8] == 2'h3 && exp_node != 6'h00)))
    begin
      if (a != NODE_SETUP_ADDR)
        wr = exp_node != 6'h00 && a >= 7'h02 && a < 7'h30 && !rsvd(a);
    end
    if (bad)
    begin
      exp_fault = 1'b1;
      exp_err = (exp_err == 3'h7) ? exp_err : exp_err + 3'h1;
    end
    send(x);
    if (live && own && x[9:8] == 2'h2 && a == NODE_SETUP_ADDR)
      exp_node = x[37:32];
    `CHK("node address", exp_node, node_address_o)
    `CHK("fault flag", exp_fault, link_fault_flag_o)
    `CHK("error count", exp_err, link_error_count_o)
    `CHK("restarts", (live && own && x[9:8] == 2'h0) ? 1 : 0, nop_cnt - t0)
    `CHK("writes", wr ? 1 : 0, wr_cnt - w0)
    if (wr)
      `CHK("write word", {x[30:24], x[47:32]}, {wr_addr, wr_data})
    `CHK("responses", n, i_fcrcd_host_model.rsp_q.size())
    while (i_fcrcd_host_model.rsp_q.size() > 0)
    begin
      got = i_fcrcd_host_model.rsp_q.pop_front();
      `CHK("response", seal({rd_val(a), 1'b1, a, 2'b00, exp_node, exp_seq, 4'h1, 8'h00}), got)
      a = a + 7'h01;
      exp_seq = exp_seq + 4'h1;
    end
    `CHK("sequence", exp_seq, response_sequence_count_o)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(11597));
    {nrst_i, rx_valid_i, link_fault_clear_i, rx_frame_i} = '0;
    {err_count, checked, wr_cnt, nop_cnt} = '0;
    {exp_node, exp_seq, exp_err, exp_fault} = '0;
    repeat (20) @(posedge clock_i);
    `CHK("reset outputs", 16'h0000, {node_address_o, response_sequence_count_o, rx_ready_o,
                                  tx_valid_o, link_fault_flag_o, link_error_count_o})
    `CHK("crc example", 48'h01010801303c, seal(48'h010108013000))
    @(negedge clock_i);
    nrst_i = 1'b1;
    do_frame(mk(2'h2, 7'h05, 6'h00, 16'h1234), 0);
    do_frame(mk(2'h3, 7'h05, 6'h00, 16'h1234), 0);
    do_frame(mk(2'h2, 7'h01, 6'h00, 16'hffea), 0);
    do_frame(mk(2'h3, 7'h01, 6'h15, 16'h0011), 0);
    do_frame(mk(2'h1, 7'h01, 6'h2a, 16'hff00), 0);
    do_frame(mk(2'h1, 7'h13, 6'h2a, 16'h0002), 0);
    do_frame(mk(2'h1, 7'h7e, 6'h2a, 16'hff03), 0);
    do_frame(mk(2'h1, 7'h20, 6'h2a, 16'h0011), 0);
    do_frame(mk(2'h2, 7'h15, 6'h2a, 16'h00aa), 0);
    do_frame(mk(2'h2, 7'h40, 6'h2a, 16'h00bb), 0);
    do_frame(mk(2'h2, 7'h04, 6'h2a, 16'hbeef), 0);
    do_frame(mk(2'h3, 7'h06, 6'h3f, 16'h5a5a), 0);
    do_frame(mk(2'h0, 7'h33, 6'h2a, 16'h0001), 0);
    do_frame(mk(2'h1, 7'h04, 6'h2b, 16'h0001), 0);
    do_frame(seal(mk(2'h1, 7'h04, 6'h2a, 16'h0001) | 48'h0000_8000_0000), 0);
    do_frame(mk(2'h1, 7'h04, 6'h2a, 16'h0001) ^ 48'h1, 1);
    do_frame(mk(2'h1, 7'h04, 6'h2a, 16'h0001), 0);
    for (int j = 0; j < 60; j++)
    begin
      f = {16'($urandom), 32'($urandom)};
      if (f[9:8] == 2'h1)
        f[39:32] = 8'($urandom % 5);
      if (f[30:24] == NODE_SETUP_ADDR)
        f[30:24] = 7'h02;
      if ($urandom % 4 != 0)
        f[21:16] = exp_node;
      f[31] = ($urandom % 8 == 0);
      f = seal(f);
      if ($urandom % 8 == 0)
        do_frame(f ^ (48'h1 << ($urandom % 48)), 1);
      else
        do_frame(f, 0);
      if ($urandom % 4 == 0)
      begin
        link_fault_clear_i = 1'b1;
        @(negedge clock_i);
        link_fault_clear_i = 1'b0;
        exp_fault = 1'b0;
        @(negedge clock_i);
        `CHK("fault cleared", 1'b0, link_fault_flag_o)
      end
    end
    end_sim;
  end
  // cut a hang short
  initial
  begin
    repeat (60000) @(posedge clock_i);
    err_count++;
    end_sim;
  end
endmodule // fcrcd_decoder_tb
